// File: hw/pmcg_pkg.sv
// types for the power mode and peripheral clock gating block
// assumes nothing beyond the constants header
package pmcg_pkg;
	typedef enum logic [3:0] {
		PMCG_RUN   = 4'b0001,
		PMCG_IDLE  = 4'b0010,
		PMCG_PDOWN = 4'b0100,
		PMCG_WAKE  = 4'b1000
	} pmcg_state_type;
endpackage

// File: hw/pmcg_regs.svh
// constants for the power mode and peripheral clock gating block
// assumes a plain address/strobe register port and a single system clock
// What this block does
// - idle stops processor clock, peripherals keep running
// - idle ends on enabled interrupt or reset
// - power-down stops oscillator and every clock
// - external interrupt wakes, clears power-down bit
// - both bits set means power-down wins
// - state and pin levels held during power-down
// - resume without losing or repeating instructions
// - brown-out off bit acts only in power-down
// - each gate bit passes or blocks peripheral clock
// - bits 1..5 timers, serials, pwm; reset one
// - watchdog, io, pin connect, sysctl have no gate bit, stop only in power-down
// - power-down clears multiplier loop enable and connect
`ifndef PMCG_REGS_SVH
`define PMCG_REGS_SVH
// ---------------------------------------------
// register map
// ---------------------------------------------
`define PMCG_ADDR_MODE      32'he01fc0c0
`define PMCG_ADDR_GATES     32'he01fc0c4
`define PMCG_BIT_IDLE       0
`define PMCG_BIT_PDOWN      1
`define PMCG_BIT_BOD_OFF    2
`define PMCG_GATE_TIM0      1
`define PMCG_GATE_PWM0      5
`define PMCG_MODE_RESET     8'h00
`define PMCG_GATES_RESET    32'h0000003e
`define PMCG_GATES_MASK     32'h0000003e
// settle counter load, cycles counted down after the wake start pulse before done, oscillator settle stand-in
`define PMCG_WAKE_CYCLES    4'h8
`endif

// File: hw/pmcg_top.sv
// power mode control and peripheral clock gate enables
// assumes clock gating cells outside take the enable levels driven here
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/100ps
`include "pmcg_regs.svh"
module pmcg_top (
	// clock and reset
	input  wire logic        I_REF_CLK,
	input  wire logic        I_RST_N,
	input  wire logic        I_CE,
	// register port
	input  wire logic [31:0] I_ADDR,
	input  wire logic [31:0] I_WDATA,
	input  wire logic        I_WR,
	input  wire logic        I_RD,
	output logic      [31:0] O_RDATA,
	// wake sources, level inputs from pins and interrupt logic
	input  wire logic        I_PERIPH_IRQ,
	input  wire logic        I_EXT_IRQ,
	// clock enables, brown-out enable, loop clear and state hold
	output logic             O_CPU_CLK_EN,
	output logic             O_OSC_EN,
	output logic             O_SYS_CLK_EN,
	output logic             O_ALWAYS_CLK_EN,
	output logic      [31:0] O_PERIPH_CLK_EN,
	output logic             O_BOD_EN,
	output logic             O_PLL_CLEAR,
	output logic             O_HOLD_STATE
);
	// ---------------------------------------------
	// input synchronisers
	// ---------------------------------------------
	logic per_m_q, per_s_q, ext_m_q, ext_s_q;
	always_ff @(posedge I_REF_CLK) begin
		if (!I_RST_N) begin
			per_m_q <= 1'b0;
			per_s_q <= 1'b0;
			ext_m_q <= 1'b0;
			ext_s_q <= 1'b0;
		end else if (I_CE) begin
			per_m_q <= I_PERIPH_IRQ;
			per_s_q <= per_m_q;
			ext_m_q <= I_EXT_IRQ;
			ext_s_q <= ext_m_q;
		end
	end

	// ---------------------------------------------
	// registers and state
	// ---------------------------------------------
	logic [7:0]                mode_q;
	logic [31:0]               gates_q;
	pmcg_pkg::pmcg_state_type  state_q;
	logic                      wake_start, wake_done;
	logic                      wr_mode, wr_gates;

	// address decode shared by the write and read paths
	function automatic logic pmcg_hit(input logic [31:0] addr, input logic [31:0] base);
		pmcg_hit = (addr == base);
	endfunction

	assign wr_mode  = I_WR && pmcg_hit(I_ADDR, `PMCG_ADDR_MODE);
	assign wr_gates = I_WR && pmcg_hit(I_ADDR, `PMCG_ADDR_GATES);
	// wake pulses only from power-down into the settle counter
	assign wake_start = I_CE && (state_q == pmcg_pkg::PMCG_PDOWN) && ext_s_q;

	pmcg_wake_timer u_wake (
		.i_clk   (I_REF_CLK),
		.i_rst_n (I_RST_N),
		.i_ce    (I_CE),
		.i_start (wake_start),
		.o_done  (wake_done)
	);

	// mode register: hardware clears win over a same-cycle write since the
	// processor is stopped while a clear can happen
	always_ff @(posedge I_REF_CLK) begin
		if (!I_RST_N) begin
			mode_q <= `PMCG_MODE_RESET;
		end else if (I_CE) begin
			if (wr_mode) begin
				mode_q <= {5'h00, I_WDATA[2:0]};
			end
			if (state_q == pmcg_pkg::PMCG_IDLE && (per_s_q || ext_s_q)) begin
				mode_q[`PMCG_BIT_IDLE] <= 1'b0;
			end
			if (wake_done) begin
				mode_q[`PMCG_BIT_PDOWN] <= 1'b0;
				mode_q[`PMCG_BIT_IDLE]  <= 1'b0;
			end
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (!I_RST_N) begin
			gates_q <= `PMCG_GATES_RESET;
		end else if (I_CE && wr_gates) begin
			gates_q <= I_WDATA & `PMCG_GATES_MASK;
		end
	end

	// ---------------------------------------------
	// mode sequencer
	// ---------------------------------------------
	always_ff @(posedge I_REF_CLK) begin
		if (!I_RST_N) begin
			state_q <= pmcg_pkg::PMCG_RUN;
		end else if (I_CE) begin
			unique case (state_q)
				pmcg_pkg::PMCG_RUN: begin
					if (mode_q[`PMCG_BIT_PDOWN]) begin
						state_q <= pmcg_pkg::PMCG_PDOWN;
					end else if (mode_q[`PMCG_BIT_IDLE]) begin
						state_q <= pmcg_pkg::PMCG_IDLE;
					end
				end
				pmcg_pkg::PMCG_IDLE: begin
					if (per_s_q || ext_s_q) begin
						state_q <= pmcg_pkg::PMCG_RUN;
					end
				end
				pmcg_pkg::PMCG_PDOWN: begin
					if (ext_s_q) begin
						state_q <= pmcg_pkg::PMCG_WAKE;
					end
				end
				pmcg_pkg::PMCG_WAKE: begin
					if (wake_done) begin
						state_q <= pmcg_pkg::PMCG_RUN;
					end
				end
				default: state_q <= pmcg_pkg::PMCG_RUN;
			endcase
		end
	end

	// ---------------------------------------------
	// clock enables, brown-out enable, loop clear, state hold and read port
	// ---------------------------------------------
	logic in_pd, bod_off;
	assign in_pd   = (state_q == pmcg_pkg::PMCG_PDOWN) || (state_q == pmcg_pkg::PMCG_WAKE);
	assign bod_off = mode_q[`PMCG_BIT_PDOWN] && mode_q[`PMCG_BIT_BOD_OFF];

	always_ff @(posedge I_REF_CLK) begin
		if (!I_RST_N) begin
			O_CPU_CLK_EN    <= 1'b1;
			O_OSC_EN        <= 1'b1;
			O_SYS_CLK_EN    <= 1'b1;
			O_ALWAYS_CLK_EN <= 1'b1;
			O_PERIPH_CLK_EN <= `PMCG_GATES_RESET;
			O_BOD_EN        <= 1'b1;
			O_PLL_CLEAR     <= 1'b0;
			O_HOLD_STATE    <= 1'b0;
			O_RDATA         <= 32'h0000_0000;
		end else if (I_CE) begin
			// cpu clock enable is registered from the run state, so it drops one cycle after the sequencer leaves run
			O_CPU_CLK_EN    <= (state_q == pmcg_pkg::PMCG_RUN);
			O_OSC_EN        <= (state_q != pmcg_pkg::PMCG_PDOWN);
			O_SYS_CLK_EN    <= !in_pd;
			O_ALWAYS_CLK_EN <= !in_pd;
			O_PERIPH_CLK_EN <= in_pd ? 32'h0000_0000 : gates_q;
			O_BOD_EN        <= !(in_pd && bod_off);
			O_PLL_CLEAR     <= (state_q == pmcg_pkg::PMCG_RUN) && mode_q[`PMCG_BIT_PDOWN];
			O_HOLD_STATE    <= in_pd;
			O_RDATA         <= 32'h0000_0000;
			if (I_RD && pmcg_hit(I_ADDR, `PMCG_ADDR_MODE)) begin
				O_RDATA <= {24'h000000, mode_q};
			end else if (I_RD && pmcg_hit(I_ADDR, `PMCG_ADDR_GATES)) begin
				O_RDATA <= gates_q;
			end
		end
	end

	// ---------------------------------------------
	// checks
	// ---------------------------------------------
	AST_PD_WINS: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
		I_CE && state_q == pmcg_pkg::PMCG_RUN && mode_q[1] |=> state_q == pmcg_pkg::PMCG_PDOWN)
		else $error("power-down did not take priority");
	AST_IDLE_CPU: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
		I_CE && state_q == pmcg_pkg::PMCG_IDLE |=> !O_CPU_CLK_EN && O_PERIPH_CLK_EN == $past(gates_q))
		else $error("idle clock enables wrong");
	AST_PD_CLK: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
		I_CE && state_q == pmcg_pkg::PMCG_PDOWN |=> !O_OSC_EN && !O_SYS_CLK_EN && O_PERIPH_CLK_EN == 32'h0)
		else $error("clock running in power-down");
	AST_WAKE_CLR: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
		wake_done && I_CE |=> !mode_q[1] && state_q == pmcg_pkg::PMCG_RUN)
		else $error("wake did not clear power-down");
	AST_IDLE_CLR: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
		I_CE && state_q == pmcg_pkg::PMCG_IDLE && per_s_q |=> !mode_q[0])
		else $error("idle bit not cleared");
	AST_BOD: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
		I_CE && !in_pd |=> O_BOD_EN)
		else $error("brown-out off outside power-down");
	AST_HOLD: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
		I_CE && in_pd |=> O_HOLD_STATE)
		else $error("state not held");
	AST_PLL: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
		I_CE && state_q == pmcg_pkg::PMCG_RUN && mode_q[1] |=> O_PLL_CLEAR)
		else $error("loop not cleared");
	AST_MASK: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
		(gates_q & ~`PMCG_GATES_MASK) == 32'h0)
		else $error("gate bit outside mask set");
	AST_ALWAYS: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
		I_CE && !in_pd |=> O_ALWAYS_CLK_EN)
		else $error("always-on clock stopped outside power-down");
	AST_GATE_WR: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
		I_CE && wr_gates |=> gates_q == ($past(I_WDATA) & `PMCG_GATES_MASK))
		else $error("gate write lost");
	AST_RDATA_ZERO: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
		I_CE && !I_RD |=> O_RDATA == 32'h0000_0000)
		else $error("read data outside read slot");
	AST_CE_FREEZE: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
		!I_CE |=> $stable(state_q) && $stable(mode_q) && $stable(gates_q))
		else $error("state moved with clock enable low");
	AST_OSC_WAKE: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
		I_CE && state_q == pmcg_pkg::PMCG_WAKE |=> O_OSC_EN)
		else $error("oscillator not restarted on wake");
	AST_IDLE_EXT: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
		I_CE && state_q == pmcg_pkg::PMCG_IDLE && ext_s_q |=> state_q == pmcg_pkg::PMCG_RUN)
		else $error("external interrupt did not end idle");
	COV_CE: cover property (@(posedge I_REF_CLK) !I_CE ##1 I_CE);
	COV_IDLE: cover property (@(posedge I_REF_CLK) state_q == pmcg_pkg::PMCG_IDLE ##1 state_q == pmcg_pkg::PMCG_RUN);
	COV_PD: cover property (@(posedge I_REF_CLK) state_q == pmcg_pkg::PMCG_WAKE ##1 state_q == pmcg_pkg::PMCG_RUN);
	COV_GATE: cover property (@(posedge I_REF_CLK) wr_gates && I_WDATA[1] == 1'b0);
endmodule

// File: hw/pmcg_wake_timer.sv
// settle counter that holds the processor clock off after power-down wake
// assumes start is a one-cycle pulse on the system clock
`timescale 1ns/100ps
`include "pmcg_regs.svh"
module pmcg_wake_timer (
	// clock and control
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_ce,
	input  wire logic       i_start,
	// status
	output logic            o_done
);
	logic [3:0] cnt_q;
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			cnt_q  <= 4'h0;
			o_done <= 1'b0;
		end else if (i_ce) begin
			o_done <= 1'b0;
			if (i_start) begin
				cnt_q <= `PMCG_WAKE_CYCLES;
			end else if (cnt_q != 4'h0) begin
				cnt_q  <= cnt_q - 4'h1;
				o_done <= (cnt_q == 4'h1);
			end
		end
	end
endmodule

// File: verif/tb_pmcg_top.sv
// self-checking bench for the power mode and peripheral clock gating block
// assumes the register port of pmcg_top and its constants header
`timescale 1ns/100ps
`include "pmcg_regs.svh"
module tb_pmcg_top;
	logic        clk = 0;
	logic        rst_n = 0;
	logic        wr = 0;
	logic        rd = 0;
	logic        p_irq = 0;
	logic        e_irq = 0;
	logic        seen = 0;
	logic        ce = 1;
	logic [31:0] addr = 0;
	logic [31:0] wdata = 0;
	logic [31:0] rdata, per_en, d, g;
	logic        cpu_en, osc_en, sys_en, alw_en, bod_en, pll_clr, hold;
	int          mismatches = 0;
	int          tests_run = 0;
	int          cyc = 0;
	int          ms[2] = '{7, 2};
	// ----------------------------------------
	// clock, design, timeout
	// ----------------------------------------
	initial forever #50 clk = ~clk;
	pmcg_top pmcg_top_i (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_CE(ce), .I_ADDR(addr), .I_WDATA(wdata),
		.I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_PERIPH_IRQ(p_irq), .I_EXT_IRQ(e_irq),
		.O_CPU_CLK_EN(cpu_en), .O_OSC_EN(osc_en), .O_SYS_CLK_EN(sys_en), .O_ALWAYS_CLK_EN(alw_en),
		.O_PERIPH_CLK_EN(per_en), .O_BOD_EN(bod_en), .O_PLL_CLEAR(pll_clr), .O_HOLD_STATE(hold));
	// whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cyc++;
		if (pll_clr === 1'b1)
			seen = 1;
		if (cyc == 5000) begin
			mismatches++;
			print_verdict;
		end
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [31:0] a, input logic [31:0] v);
		@(posedge clk);
		wr <= 1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rd_reg(input logic [31:0] a);
		@(posedge clk);
		rd <= 1;
		addr <= a;
		@(posedge clk);
		rd <= 0;
		#1 d = rdata;
	endtask
	task automatic settle;
		repeat (4) @(posedge clk);
		#1;
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		void'($urandom(7));
		repeat (20) @(posedge clk);
		rst_n <= 1;
		@(posedge clk);
		#1;
		chk({cpu_en, osc_en, sys_en, alw_en, bod_en, hold}, 6'b111110);
		chk(per_en, 32'h3e);
		rd_reg(`PMCG_ADDR_MODE);
		chk(d, 0);
		rd_reg(`PMCG_ADDR_GATES);
		chk(d, 32'h3e);
		rd_reg(32'he01fc0c8);
		chk(d, 0);
		// zero and all ones first, then random gate patterns
		for (int i = 0; i < 8; i++) begin
			g = (i == 0) ? 32'h0 : (i == 1) ? 32'hffffffff : $urandom;
			wr_reg(`PMCG_ADDR_GATES, g);
			g = g & 32'h3e;
			rd_reg(`PMCG_ADDR_GATES);
			chk(d, g);
			chk(per_en, g);
			chk(alw_en, 1);
		end
		wr_reg(32'he01fc0c8, 32'h0);
		rd_reg(`PMCG_ADDR_GATES);
		chk(d, g);
		// idle entry and peripheral interrupt exit
		wr_reg(`PMCG_ADDR_MODE, 32'h1);
		settle;
		chk({cpu_en, sys_en, alw_en}, 3'b011);
		chk(per_en, g);
		p_irq <= 1;
		repeat (40) if (cpu_en !== 1'b1) @(posedge clk);
		#1;
		chk(cpu_en, 1);
		p_irq <= 0;
		rd_reg(`PMCG_ADDR_MODE);
		chk(d, 0);
		// power-down with both bits and brown-out off, then brown-out kept
		foreach (ms[k]) begin
			seen = 0;
			wr_reg(`PMCG_ADDR_MODE, ms[k]);
			settle;
			chk({cpu_en, osc_en, sys_en, alw_en, hold}, 5'b00001);
			chk(per_en, 0);
			chk(bod_en, (ms[k] == 7) ? 0 : 1);
			chk(seen, 1);
			seen = 0;
			e_irq <= 1;
			repeat (40) if (cpu_en !== 1'b1) @(posedge clk);
			#1;
			chk({cpu_en, osc_en, hold}, 3'b110);
			chk(per_en, g);
			e_irq <= 0;
			rd_reg(`PMCG_ADDR_MODE);
			chk(d & 32'h2, 0);
			chk(seen, 0);
		end
		// clock enable low freezes the gate register
		ce <= 0;
		wr_reg(`PMCG_ADDR_GATES, 32'h0);
		ce <= 1;
		rd_reg(`PMCG_ADDR_GATES);
		chk(d, g);
		// idle left through the external interrupt
		wr_reg(`PMCG_ADDR_MODE, 32'h1);
		settle;
		chk(cpu_en, 0);
		e_irq <= 1;
		repeat (40) if (cpu_en !== 1'b1) @(posedge clk);
		#1;
		chk(cpu_en, 1);
		e_irq <= 0;
		rd_reg(`PMCG_ADDR_MODE);
		chk(d, 0);
		// reset in mid-run ends power-down
		wr_reg(`PMCG_ADDR_MODE, 32'h2);
		settle;
		chk(osc_en, 0);
		rst_n <= 0;
		repeat (2) @(posedge clk);
		rst_n <= 1;
		@(posedge clk);
		#1;
		chk({cpu_en, osc_en, hold}, 3'b110);
		chk(per_en, 32'h3e);
		rd_reg(`PMCG_ADDR_MODE);
		chk(d, 0);
		print_verdict;
	end
endmodule
